/* rtl/card_cfg_pkg.sv */
// package with register layout, reset values and bus constants for the card translator config
package card_cfg_pkg;
	localparam int DATA_W = 8;
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A; // arbitrary neutral address
	localparam logic [7:0] DEVICE_CONFIG_OFFSET = 8'h00;
	localparam logic [7:0] DEVICE_CONFIG_RESET = 8'h00;
	localparam int REG_DIS_POS = 7;
	localparam int ROLE_POS = 6;
	localparam int RST_LVL_POS = 5;
	localparam int FREEZE_POS = 4;
	localparam int POL_POS = 3;
	localparam int RSVD_POS = 2;
	localparam int VSEL_POS = 1;
	localparam int EN_POS = 0;
	localparam logic [7:0] WRITE_MASK = 8'hFB; // reserved bit never stored
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WDATA = 3'b011,
		ST_WACK = 3'b100,
		ST_RDATA = 3'b101,
		ST_RACK = 3'b110,
		ST_WAIT = 3'b111
	} bus_state_type;
endpackage

/* rtl/card_cfg_if.sv */
// interface carrying decoded bus writes and the readback byte between slave and register
`timescale 1ns/1ps
interface card_cfg_if;
	logic wr_stb;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	modport slave (output wr_stb, output wr_data, input rd_data);
	modport regs (input wr_stb, input wr_data, output rd_data);
endinterface

/* rtl/card_cfg_serial.sv */
// two-wire serial slave with one register and no subaddress
`timescale 1ns/1ps
module card_cfg_serial
	import card_cfg_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
)
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// synchronised bus lines
	input wire logic i_scl,
	input wire logic i_sda,
	// data line drive
	output logic o_sda_oe,
	// register side
	card_cfg_if.slave cfg
);
	bus_state_type state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic scl_d_reg, sda_d_reg, sda_oe_reg, sda_oe_next, wr_stb_next;
	logic [7:0] wr_data_reg;
	logic pend_reg, pend_next;
	wire scl_rise = i_scl & ~scl_d_reg;
	wire scl_fall = ~i_scl & scl_d_reg;
	wire start_cond = i_scl & scl_d_reg & sda_d_reg & ~i_sda;
	wire stop_cond = i_scl & scl_d_reg & ~sda_d_reg & i_sda;
	wire addr_hit = (shift_reg[7:1] == SLAVE_ADDR);

	assign o_sda_oe = sda_oe_reg;
	assign cfg.wr_data = wr_data_reg;

	// byte engine: address byte then one data byte, msb first
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		sda_oe_next = sda_oe_reg;
		pend_next = pend_reg;
		wr_stb_next = 1'b0;
		// received bits are counted on rising clock edges, so the fall that follows
		// the start condition is not mistaken for a data bit
		unique case (state_reg)
			ST_IDLE, ST_WAIT: ;
			ST_ADDR:
				if (scl_rise && cnt_reg <= BIT_LAST)
				begin
					shift_next = {shift_reg[6:0], i_sda};
					cnt_next = cnt_reg + 4'h1;
				end
				else if (scl_fall && cnt_reg == BIT_ACK)
				begin
					// ack is driven through the whole ninth clock
					state_next = addr_hit ? ST_ADDR_ACK : ST_WAIT;
					sda_oe_next = addr_hit;
				end
			ST_ADDR_ACK:
				if (scl_fall)
				begin
					cnt_next = 4'h0;
					if (shift_reg[0])
					begin
						state_next = ST_RDATA;
						shift_next = cfg.rd_data;
						sda_oe_next = ~cfg.rd_data[7];
					end
					else
					begin
						state_next = ST_WDATA;
						sda_oe_next = 1'b0;
					end
				end
			ST_WDATA:
				if (scl_rise && cnt_reg <= BIT_LAST)
				begin
					shift_next = {shift_reg[6:0], i_sda};
					cnt_next = cnt_reg + 4'h1;
				end
				else if (scl_fall && cnt_reg == BIT_ACK)
				begin
					state_next = ST_WACK;
					sda_oe_next = 1'b1;
				end
			ST_WACK:
				if (scl_fall)
				begin
					// update waits for stop, as the internal write does
					pend_next = 1'b1;
					state_next = ST_WAIT;
					sda_oe_next = 1'b0;
				end
			ST_RDATA:
				if (scl_fall)
				begin
					cnt_next = cnt_reg + 4'h1;
					shift_next = {shift_reg[6:0], 1'b1};
					sda_oe_next = (cnt_reg < BIT_LAST) ? ~shift_reg[6] : 1'b0;
					if (cnt_reg == BIT_LAST)
						state_next = ST_RACK;
				end
			ST_RACK:
				// ack or nack from the master are both accepted
				if (scl_fall)
					state_next = ST_WAIT;
		endcase
		if (start_cond)
		begin
			state_next = ST_ADDR;
			cnt_next = 4'h0;
			sda_oe_next = 1'b0;
			pend_next = 1'b0;
		end
		else if (stop_cond)
		begin
			state_next = ST_IDLE;
			sda_oe_next = 1'b0;
			wr_stb_next = pend_reg;
			pend_next = 1'b0;
		end
	end

	// bus state registers
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
			pend_reg <= 1'b0;
			wr_data_reg <= 8'h00;
			cfg.wr_stb <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			scl_d_reg <= i_scl;
			sda_d_reg <= i_sda;
			sda_oe_reg <= sda_oe_next;
			pend_reg <= pend_next;
			if (state_reg == ST_WACK && scl_fall)
				wr_data_reg <= shift_reg;
			cfg.wr_stb <= wr_stb_next;
		end
	end
endmodule

/* rtl/card_translator_cfg.sv */
// configuration register and card-side output control of the card interface translator
// Operation
// - bit 7 set turns the regulator off
// - bit 6 clear passes host reset through
// - bit 6 set makes pin an enable
// - bit 3 selects enable pin polarity
// - bit 5 drives card reset in enable mode
// - bit 4 freezes card data and clock at inputs, and card reset too in pass-through mode
// - bit 1 selects 1.8 V or 3 V
// - bit 0 enables; read-only pin state in enable mode
// - modes valid only under serial-bus control
// - address byte then one data byte
// - reset loads defaults into register and engine
`timescale 1ns/1ps
module card_translator_cfg
	import card_cfg_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
)
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// serial bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// host side inputs
	input wire logic i_host_reset_en,
	input wire logic i_host_data,
	input wire logic i_host_clock,
	// card side outputs
	output logic o_card_reset_out,
	output logic o_card_data_io,
	output logic o_card_clock_out,
	// regulator and device control
	output logic o_regulator_enable,
	output logic o_supply_voltage_3v,
	output logic o_device_enable,
	// register readback
	output logic [7:0] o_device_config
);
	card_cfg_if cfg ();
	logic [1:0] scl_sync_reg, sda_sync_reg, pin_sync_reg, data_sync_reg, clk_sync_reg;
	logic [7:0] device_config_reg;
	logic frz_data_reg, frz_clock_reg, frz_reset_reg;
	logic card_reset_reg, card_data_reg, card_clock_reg;

	// two-stage synchronisers for every pin input
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			pin_sync_reg <= 2'h0;
			data_sync_reg <= 2'h3;
			clk_sync_reg <= 2'h0;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], i_scl};
			sda_sync_reg <= {sda_sync_reg[0], i_sda};
			pin_sync_reg <= {pin_sync_reg[0], i_host_reset_en};
			data_sync_reg <= {data_sync_reg[0], i_host_data};
			clk_sync_reg <= {clk_sync_reg[0], i_host_clock};
		end
	end

	wire pin_lvl = pin_sync_reg[1];
	wire role_en = device_config_reg[ROLE_POS];
	wire freeze = device_config_reg[FREEZE_POS];

	card_cfg_serial #(.SLAVE_ADDR(SLAVE_ADDR)) u_serial
	(
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_scl(scl_sync_reg[1]),
		.i_sda(sda_sync_reg[1]),
		.o_sda_oe(o_sda_oe),
		.cfg(cfg.slave)
	);
	// open drain: only ever pulls low
	assign o_sda_out = 1'b0;

	// enable bit reads pin in enable mode
	assign cfg.rd_data = role_en
		? {device_config_reg[7:1], pin_lvl}
		: device_config_reg;

	// enable bit write guard
	// when the written byte sets bit 6 the written enable bit is dropped and the stored one kept
	wire keep_en = cfg.wr_data[ROLE_POS];
	wire new_en = keep_en ? device_config_reg[EN_POS] : cfg.wr_data[EN_POS];
	wire [7:0] config_write = {cfg.wr_data[7:1] & WRITE_MASK[7:1], new_en};

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			device_config_reg <= DEVICE_CONFIG_RESET;
		else if (cfg.wr_stb)
			device_config_reg <= config_write;
	end

	// pin acts as enable in enable mode
	wire pin_enable = device_config_reg[POL_POS] ? ~pin_lvl : pin_lvl;
	// modes apply under bus control only
	wire dev_en = role_en ? pin_enable : device_config_reg[EN_POS];

	wire reset_src = role_en ? device_config_reg[RST_LVL_POS] : pin_lvl;

	// freeze capture: levels held while the freeze bit stands
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			frz_data_reg <= 1'b1;
			frz_clock_reg <= 1'b0;
			frz_reset_reg <= 1'b0;
		end
		else if (!freeze)
		begin
			frz_data_reg <= data_sync_reg[1];
			frz_clock_reg <= clk_sync_reg[1];
			frz_reset_reg <= pin_lvl;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			card_data_reg <= 1'b1;
			card_clock_reg <= 1'b0;
			card_reset_reg <= 1'b0;
		end
		else
		begin
			card_data_reg <= freeze ? frz_data_reg : data_sync_reg[1];
			card_clock_reg <= freeze ? frz_clock_reg : clk_sync_reg[1];
			// reset is frozen only in pass-through mode
			card_reset_reg <= (freeze && !role_en) ? frz_reset_reg : reset_src;
		end
	end

	assign o_card_data_io = card_data_reg;
	assign o_card_clock_out = card_clock_reg;
	assign o_card_reset_out = card_reset_reg;
	assign o_regulator_enable = ~device_config_reg[REG_DIS_POS];
	assign o_supply_voltage_3v = device_config_reg[VSEL_POS];
	assign o_device_enable = dev_en;
	assign o_device_config = cfg.rd_data;
endmodule

/* verif/card_cfg_assertions.sv */
// assertion checker for the card translator config block
`timescale 1ns/1ps
module card_cfg_assertions
	import card_cfg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic o_sda_oe,
	input wire logic i_host_reset_en,
	input wire logic i_host_data,
	input wire logic i_host_clock,
	input wire logic o_card_reset_out,
	input wire logic o_card_data_io,
	input wire logic o_card_clock_out,
	input wire logic o_regulator_enable,
	input wire logic o_supply_voltage_3v,
	input wire logic o_device_enable,
	input wire logic [7:0] o_device_config
);
	wire [7:0] c = o_device_config;
	logic [3:0] alive_reg;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// warm-up, so the three-cycle path never sees inputs from before reset
	always_ff @(posedge i_clk_sys or negedge i_nrst)
		if (!i_nrst)
			alive_reg <= 4'h0;
		else
			alive_reg <= {alive_reg[2:0], 1'h1};
	// modes held long enough for the output pipeline to settle
	sequence pass_held;
		(&alive_reg && !c[6] && !c[4]) [*4];
	endsequence
	sequence lvl_held;
		(c[6] && $stable(c[5])) [*4];
	endsequence
	sequence frz_held;
		(c[4] && $stable(c[7:1])) [*6];
	endsequence
	reg_off_a: assert property (o_regulator_enable == !c[7])
		else $error("regulator enable wrong");
	pass_thru_a: assert property (pass_held |-> {o_card_reset_out, o_card_data_io,
		o_card_clock_out} == {$past(i_host_reset_en, 3), $past(i_host_data, 3),
		$past(i_host_clock, 3)}) else $error("card outputs not following host");
	card_level_a: assert property (lvl_held |-> o_card_reset_out == c[5])
		else $error("card reset level wrong");
	en_map_a: assert property (o_device_enable == (c[0] ^ (c[6] & c[3])))
		else $error("device enable wrong");
	freeze_hold_a: assert property (frz_held |->
		$stable({o_card_reset_out, o_card_data_io, o_card_clock_out})) else $error("freeze lost");
	volt_sel_a: assert property (o_supply_voltage_3v == c[1])
		else $error("voltage select wrong");
	rsvd_zero_a: assert property (c[2] == 1'h0)
		else $error("reserved bit set");
	sda_change_a: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("data line moved with clock high");
	reset_dflt_a: assert property ($rose(i_nrst) |-> c == DEVICE_CONFIG_RESET && !o_sda_oe)
		else $error("reset default wrong");
endmodule

/* verif/card_host_model.sv */
// host-side two-wire bus master that reaches the config register
`timescale 1ns/1ps
module card_host_model
(
	// system clock paces the bus phases
	input wire logic i_clk,
	input wire logic i_sda,
	// bus drive, data pulled low only
	output logic o_scl,
	output logic o_sda_pull
);
	// idle bus: clock high, data left to the pull-up
	initial
	begin
		o_scl = 1'h1;
		o_sda_pull = 1'h0;
	end
	// eight cycles a phase, well past the synchroniser lag
	task automatic wait_phase();
		repeat (8) @(negedge i_clk);
	endtask
	// data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		o_sda_pull = !b;
		wait_phase();
		o_scl = 1'h1;
		wait_phase();
		r = i_sda;
		o_scl = 1'h0;
		wait_phase();
	endtask
	// start, address byte, one data byte msb first, stop
	task automatic frame(input logic [6:0] a, input logic rd, input logic [7:0] wd,
		output logic [7:0] q, output logic nk);
		logic r;
		o_sda_pull = 1'h1;
		wait_phase();
		o_scl = 1'h0;
		wait_phase();
		for (int i = 7; i >= 0; i--)
			bit_io(i == 0 ? rd : a[i - 1], r);
		bit_io(1'h1, nk);
		for (int i = 7; i >= 0; i--)
			bit_io(rd | wd[i], q[i]);
		bit_io(1'h1, r);
		if (!rd)
			nk = nk | r;
		o_sda_pull = 1'h1;
		wait_phase();
		o_scl = 1'h1;
		wait_phase();
		o_sda_pull = 1'h0;
		wait_phase();
	endtask
endmodule

/* verif/card_translator_cfg_tb_top.sv */
// self-checking bench for the card translator config block
`timescale 1ns/1ps
module card_translator_cfg_tb_top
	import card_cfg_pkg::*;
;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [2:0] host = 3'h0;
	logic [2:0] frz = 3'h0;
	logic scl, pull, sda_oe, rst_o, dat_o, clk_o, reg_en, v3, dev_en;
	logic [7:0] cfg;
	int num_errors = 0;
	int samples_checked = 0;
	// open-drain data line with pull-up
	wire sda = !(pull || sda_oe);
	initial
		forever #2.5 clk = !clk;
	card_host_model host_u (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
	card_translator_cfg dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda),
		.o_sda_out(), .o_sda_oe(sda_oe), .i_host_reset_en(host[2]), .i_host_data(host[1]),
		.i_host_clock(host[0]), .o_card_reset_out(rst_o), .o_card_data_io(dat_o),
		.o_card_clock_out(clk_o), .o_regulator_enable(reg_en), .o_supply_voltage_3v(v3),
		.o_device_enable(dev_en), .o_device_config(cfg));
	task automatic report_and_stop();
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	// readback: reserved bit zero, bit 0 shows the pin in enable mode
	function automatic logic [7:0] exp_cfg(input logic [7:0] v, input logic pin);
		return {v[7:3], 1'h0, v[1], v[6] ? pin : v[0]};
	endfunction
	// m0 low after a write that goes from enable mode back to pass-through, where bit 0 goes unchecked
	task automatic verify(input logic [7:0] v, input logic m0);
		logic [7:0] q;
		logic nk;
		chk_byte(cfg & {7'h7F, m0}, exp_cfg(v, host[2]) & {7'h7F, m0});
		chk_bit(reg_en, !v[7]);
		chk_bit(v3, v[1]);
		if (m0)
			chk_bit(dev_en, v[6] ? host[2] ^ v[3] : v[0]);
		chk_bit(rst_o, v[6] ? v[5] : v[4] ? frz[2] : host[2]);
		chk_bit(dat_o, v[4] ? frz[1] : host[1]);
		chk_bit(clk_o, v[4] ? frz[0] : host[0]);
		host_u.frame(SLAVE_ADDR_DEFAULT, 1'h1, 8'h00, q, nk);
		chk_bit(nk, 1'h0);
		chk_byte(q & {7'h7F, m0}, exp_cfg(v, host[2]) & {7'h7F, m0});
	endtask
	// main sequence: fixed corners first, then random settings and host levels
	initial
	begin
		logic [7:0] v;
		logic [7:0] q;
		logic nk;
		logic m0;
		logic old6;
		v = $urandom(31526);
		old6 = 1'h0;
		repeat (20) @(negedge clk);
		nrst = 1'h1;
		repeat (8) @(negedge clk);
		verify(DEVICE_CONFIG_RESET, 1'h1);
		for (int i = 0; i < 12; i++)
		begin
			v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			if (i[0])
				v[4] = 1'h0;
			host = 3'($urandom);
			if (v[4])
				frz = host;
			m0 = !(old6 && !v[6]);
			host_u.frame(SLAVE_ADDR_DEFAULT, 1'h0, v, q, nk);
			chk_bit(nk, 1'h0);
			verify(v, m0);
			host = 3'($urandom);
			repeat (6) @(negedge clk);
			verify(v, m0);
			old6 = v[6];
		end
		// a foreign address must be ignored
		host_u.frame(SLAVE_ADDR_DEFAULT ^ 7'h01, 1'h0, ~v, q, nk);
		chk_bit(nk, 1'h1);
		verify(v, m0);
		report_and_stop();
	end
	// watchdog, several times the expected run length
	initial
	begin
		#400000;
		num_errors++;
		report_and_stop();
	end
endmodule
bind card_translator_cfg card_cfg_assertions chk_u (.*);
